// >>> core/dof_pkg.sv
// Constants for the digital output fault control block
package dof_pkg;
  localparam int          NUM_MOD      = 9;
  localparam int          NUM_GRP      = 4;
  localparam logic [15:0] IDX_ERR_RST  = 16'h5000;
  localparam logic [15:0] IDX_DIAG     = 16'h5200;
  localparam logic [15:0] IDX_MASK     = 16'h5201;
  localparam logic [15:0] IDX_SUMMARY  = 16'h5202;
  localparam logic [15:0] IDX_VALUE    = 16'h6200;
  localparam logic [15:0] IDX_POL      = 16'h6202;
  localparam logic [15:0] IDX_FMODE    = 16'h6206;
  localparam logic [15:0] IDX_FSUBST   = 16'h6207;
  localparam logic [15:0] ERR_RST_DO   = 16'h0002;
  localparam logic [7:0]  SUB_COUNT    = 8'h00;
  localparam logic [7:0]  SUB_FIRST    = 8'h01;
  localparam logic [7:0]  SUB_LAST     = 8'h09;
  localparam logic [15:0] MOD_COUNT    = 16'h0009;
  localparam logic [7:0]  MASK_RST     = 8'h0f;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam int          OPEN_OFS     = 4;
endpackage : dof_pkg

// >>> core/dof_ctrl.sv
// Digital output objects with polarity, fault substitution and diagnostics
`timescale 1ns/1ns
`default_nettype none

module dof_ctrl
  import dof_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        obj_wr,
  input  wire logic        obj_rd,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_subidx,
  input  wire logic [15:0] obj_wdata,
  output logic      [15:0] obj_rdata,
  output logic             obj_ack,
  output logic             obj_err,
  input  wire logic        bus_off,
  input  wire logic        life_guard_fail,
  input  wire logic [35:0] diag_detect,
  input  wire logic [8:0]  supply_missing,
  input  wire logic [8:0]  module_4ch,
  output logic      [71:0] out_pins,
  output logic             fault_active,
  output logic             emcy_req
);

  logic [7:0]  value      [NUM_MOD];
  logic [7:0]  polarity   [NUM_MOD];
  logic [7:0]  fmode      [NUM_MOD];
  logic [7:0]  fsubst     [NUM_MOD];
  logic [7:0]  mask       [NUM_MOD];
  logic [7:0]  flags      [NUM_MOD];
  logic [7:0]  snap       [NUM_MOD];
  logic [8:0]  summary_q;
  logic [7:0]  next_value    [NUM_MOD];
  logic [7:0]  next_polarity [NUM_MOD];
  logic [7:0]  next_fmode    [NUM_MOD];
  logic [7:0]  next_fsubst   [NUM_MOD];
  logic [7:0]  next_mask     [NUM_MOD];
  logic [7:0]  next_flags    [NUM_MOD];
  logic [7:0]  next_snap     [NUM_MOD];
  logic [8:0]  summary;
  logic [71:0] next_out_pins;
  logic        next_fault_active;
  logic        next_emcy_req;
  logic [15:0] next_obj_rdata;
  logic        next_obj_ack;
  logic        next_obj_err;

  // Decode and classification scratch
  logic        sel_value;
  logic        sel_pol;
  logic        sel_fmode;
  logic        sel_fsubst;
  logic        sel_mask;
  logic        sel_err_rst;
  logic        sub_ok;
  logic [3:0]  mod_sel;
  logic        hit;
  logic        rdonly;
  logic        out_write;
  logic        err_reset;
  logic [7:0]  det_flags;
  logic        grp_high;
  logic        grp_det;

  // Index decode shared by the table writes
  always_comb begin
    sel_value   = (obj_index == IDX_VALUE);
    sel_pol     = (obj_index == IDX_POL);
    sel_fmode   = (obj_index == IDX_FMODE);
    sel_fsubst  = (obj_index == IDX_FSUBST);
    sel_mask    = (obj_index == IDX_MASK);
    sel_err_rst = (obj_index == IDX_ERR_RST);
    sub_ok = (obj_subidx >= SUB_FIRST) && (obj_subidx <= SUB_LAST);
    mod_sel = 4'(obj_subidx - SUB_FIRST);
    // Any module's value or polarity write releases the global fault
    out_write = obj_wr && sub_ok && (sel_value || sel_pol);
    err_reset = obj_wr && sel_err_rst && (obj_subidx == SUB_COUNT)
                && (obj_wdata == ERR_RST_DO);
    for (int m = 0; m < NUM_MOD; m++) begin
      next_value[m]    = value[m];
      next_polarity[m] = polarity[m];
      next_fmode[m]    = fmode[m];
      next_fsubst[m]   = fsubst[m];
      next_mask[m]     = mask[m];
      if (obj_wr && sub_ok && (mod_sel == 4'(m))) begin
        if (sel_value) begin
          next_value[m] = obj_wdata[7:0];
        end else if (sel_pol) begin
          next_polarity[m] = obj_wdata[7:0];
        end else if (sel_fmode) begin
          next_fmode[m] = obj_wdata[7:0];
        end else if (sel_fsubst) begin
          next_fsubst[m] = obj_wdata[7:0];
        end else if (sel_mask) begin
          next_mask[m] = obj_wdata[7:0];
        end
      end
    end
  end

  // Diagnostic flags, classification and self-clear
  always_comb begin
    for (int m = 0; m < NUM_MOD; m++) begin
      det_flags = 8'h00;
      for (int g = 0; g < NUM_GRP; g++) begin
        grp_high = module_4ch[m] ? out_pins[8*m+g]
                                 : (out_pins[8*m+2*g] | out_pins[8*m+2*g+1]);
        grp_det = diag_detect[NUM_GRP*m+g] | supply_missing[m];
        det_flags[g] = grp_det & grp_high;
        det_flags[g+OPEN_OFS] = grp_det & ~grp_high;
      end
      next_snap[m]  = snap[m];
      next_flags[m] = flags[m];
      if (err_reset) begin
        next_flags[m] = BYTE_RST;
      end else if ((det_flags == BYTE_RST) && (out_pins[8*m +: 8] == snap[m])) begin
        next_flags[m] = BYTE_RST;
      end
      // New detections win over any clear in the same cycle
      next_flags[m] = next_flags[m] | det_flags;
      if ((det_flags & ~flags[m]) != BYTE_RST) begin
        next_snap[m] = out_pins[8*m +: 8];
      end
      summary[m] = (flags[m] & mask[m]) != BYTE_RST;
    end
  end

  // Fault condition and pin drive
  always_comb begin
    next_emcy_req = |(summary & ~summary_q);
    next_fault_active = fault_active;
    if (out_write) begin
      next_fault_active = 1'b0;
    end
    // Fault sources win over the release write
    if (bus_off || life_guard_fail || next_emcy_req) begin
      next_fault_active = 1'b1;
    end
    for (int m = 0; m < NUM_MOD; m++) begin
      for (int b = 0; b < 8; b++) begin
        if (next_fault_active && next_fmode[m][b]) begin
          next_out_pins[8*m+b] = next_fsubst[m][b];
        end else begin
          next_out_pins[8*m+b] = next_value[m][b] ^ next_polarity[m][b];
        end
      end
    end
  end

  // Object read and write answers
  always_comb begin
    hit = 1'b1;
    rdonly = 1'b0;
    next_obj_rdata = 16'h0000;
    if (obj_index == IDX_SUMMARY && obj_subidx == SUB_COUNT) begin
      next_obj_rdata = {7'h00, summary};
      rdonly = 1'b1;
    end else if (obj_index == IDX_ERR_RST && obj_subidx == SUB_COUNT) begin
      next_obj_rdata = 16'h0000;
    end else if (obj_subidx == SUB_COUNT && (obj_index == IDX_VALUE || obj_index == IDX_POL
                 || obj_index == IDX_FMODE || obj_index == IDX_FSUBST
                 || obj_index == IDX_DIAG || obj_index == IDX_MASK)) begin
      next_obj_rdata = MOD_COUNT;
      rdonly = 1'b1;
    end else if (!sub_ok) begin
      hit = 1'b0;
    end else if (obj_index == IDX_VALUE) begin
      next_obj_rdata = {8'h00, value[mod_sel]};
    end else if (obj_index == IDX_POL) begin
      next_obj_rdata = {8'h00, polarity[mod_sel]};
    end else if (obj_index == IDX_FMODE) begin
      next_obj_rdata = {8'h00, fmode[mod_sel]};
    end else if (obj_index == IDX_FSUBST) begin
      next_obj_rdata = {8'h00, fsubst[mod_sel]};
    end else if (obj_index == IDX_MASK) begin
      next_obj_rdata = {8'h00, mask[mod_sel]};
    end else if (obj_index == IDX_DIAG) begin
      next_obj_rdata = {8'h00, flags[mod_sel]};
      rdonly = 1'b1;
    end else begin
      hit = 1'b0;
    end
    if (!obj_rd) begin
      next_obj_rdata = obj_rdata;
    end
    next_obj_ack = obj_rd | obj_wr;
    next_obj_err = (obj_rd | obj_wr) & (~hit | (obj_wr & rdonly));
  end

  // Object table registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int m = 0; m < NUM_MOD; m++) begin
        value[m]    <= BYTE_RST;
        polarity[m] <= BYTE_RST;
        fmode[m]    <= BYTE_RST;
        fsubst[m]   <= BYTE_RST;
        mask[m]     <= MASK_RST;
      end
    end else begin
      for (int m = 0; m < NUM_MOD; m++) begin
        value[m]    <= next_value[m];
        polarity[m] <= next_polarity[m];
        fmode[m]    <= next_fmode[m];
        fsubst[m]   <= next_fsubst[m];
        mask[m]     <= next_mask[m];
      end
    end
  end

  // Diagnostic flags, snapshots and summary history
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int m = 0; m < NUM_MOD; m++) begin
        flags[m] <= BYTE_RST;
        snap[m]  <= BYTE_RST;
      end
      summary_q <= '0;
    end else begin
      for (int m = 0; m < NUM_MOD; m++) begin
        flags[m] <= next_flags[m];
        snap[m]  <= next_snap[m];
      end
      summary_q <= summary;
    end
  end

  // Fault state and pin drive
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_pins     <= '0;
      fault_active <= 1'b0;
      emcy_req     <= 1'b0;
    end else begin
      out_pins     <= next_out_pins;
      fault_active <= next_fault_active;
      emcy_req     <= next_emcy_req;
    end
  end

  // Object answers
  always_ff @(posedge mclk) begin
    if (rst) begin
      obj_rdata <= '0;
      obj_ack   <= 1'b0;
      obj_err   <= 1'b0;
    end else begin
      obj_rdata <= next_obj_rdata;
      obj_ack   <= next_obj_ack;
      obj_err   <= next_obj_err;
    end
  end

endmodule : dof_ctrl
`default_nettype wire

// >>> test/dof_monitor.sv
// Assertion checker for the digital output fault control block
`timescale 1ns/1ns
`default_nettype none
module dof_monitor
  import dof_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        obj_wr,
  input wire logic        obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [7:0]  obj_subidx,
  input wire logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata,
  input wire logic        obj_ack,
  input wire logic        obj_err,
  input wire logic        bus_off,
  input wire logic        life_guard_fail,
  input wire logic [35:0] diag_detect,
  input wire logic [8:0]  supply_missing,
  input wire logic [8:0]  module_4ch,
  input wire logic [71:0] out_pins,
  input wire logic        fault_active,
  input wire logic        emcy_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_req; obj_wr || obj_rd; endsequence
  sequence s_ro_wr; obj_wr && (obj_index == IDX_DIAG || obj_index == IDX_SUMMARY); endsequence
  AST_ACK: assert property (s_req |=> obj_ack) else $error("ack missing");
  AST_IDLE: assert property (!(obj_wr || obj_rd) |=> !obj_ack && !obj_err) else $error("ack without request");
  AST_RO: assert property (s_ro_wr |=> obj_err) else $error("read-only write accepted");
  AST_SUM_HI: assert property (obj_rd && obj_index == IDX_SUMMARY |=> obj_rdata[15:9] == 7'h00)
    else $error("summary high bits set");
  AST_CNT: assert property (obj_rd && obj_index == IDX_VALUE && obj_subidx == SUB_COUNT |=> obj_rdata == MOD_COUNT)
    else $error("module count wrong");
  AST_SRC: assert property (bus_off || life_guard_fail |=> fault_active) else $error("no fault on source");
  AST_HOLD: assert property (fault_active && !obj_wr |=> fault_active) else $error("fault dropped");
  AST_EMCY: assert property (emcy_req |-> fault_active) else $error("emergency without fault");
endmodule : dof_monitor
bind dof_ctrl dof_monitor dof_monitor_i (.mclk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_subidx, .obj_wdata,
  .obj_rdata, .obj_ack, .obj_err, .bus_off, .life_guard_fail, .diag_detect, .supply_missing, .module_4ch,
  .out_pins, .fault_active, .emcy_req);
`default_nettype wire

// >>> test/dof_master.sv
// Network master model issuing object accesses
`timescale 1ns/1ns
`default_nettype none
module dof_master (
  input wire logic        mclk,
  input wire logic [15:0] obj_rdata,
  input wire logic        obj_ack,
  input wire logic        obj_err,
  output logic            obj_wr     = 1'b0,
  output logic            obj_rd     = 1'b0,
  output logic     [15:0] obj_index  = 16'h0000,
  output logic     [7:0]  obj_subidx = 8'h00,
  output logic     [15:0] obj_wdata  = 16'h0000
);
  // Released index, subindex and data lines show the inverse so stale values cannot pass; wr and rd drop to 0
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
                        output logic [15:0] r, output logic e, output logic a);
    @(negedge mclk);
    {obj_wr, obj_rd, obj_index, obj_subidx, obj_wdata} = {w, !w, i, s, d};
    @(negedge mclk);
    {r, e, a} = {obj_rdata, obj_err, obj_ack};
    {obj_wr, obj_rd, obj_index, obj_subidx, obj_wdata} = {2'b00, ~i, ~s, ~d};
  endtask : access
endmodule : dof_master
`default_nettype wire

// >>> test/digital_output_fault_control_bench.sv
// Self-checking bench for the digital output fault control block
`timescale 1ns/1ns
`default_nettype none
module digital_output_fault_control_bench;
  import dof_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, bus_off = 1'b0, life_guard_fail = 1'b0, er, ak, flt = 1'b0;
  logic        obj_wr, obj_rd, obj_ack, obj_err, fault_active, emcy_req;
  logic [15:0] obj_index, obj_wdata, obj_rdata, rd;
  logic [7:0]  obj_subidx;
  logic [35:0] diag_detect = '0;
  logic [8:0]  supply_missing = '0, module_4ch = '0;
  logic [71:0] out_pins;
  logic [15:0] rw_idx [4] = '{IDX_VALUE, IDX_POL, IDX_FMODE, IDX_FSUBST};
  int          errors, check_count, n_emcy, v [9], p [9], fm [9], fs [9];
  dof_ctrl dof_ctrl_i (.mclk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_subidx, .obj_wdata, .obj_rdata, .obj_ack,
    .obj_err, .bus_off, .life_guard_fail, .diag_detect, .supply_missing, .module_4ch, .out_pins, .fault_active,
    .emcy_req);
  dof_master dof_master_i (.mclk, .obj_rdata, .obj_ack, .obj_err, .obj_wr, .obj_rd, .obj_index, .obj_subidx,
    .obj_wdata);
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [71:0] pins_exp();
    logic [71:0] r;
    for (int m = 0; m < NUM_MOD; m++)
      r[8*m+:8] = flt ? 8'((fm[m] & fs[m]) | (~fm[m] & (v[m] ^ p[m]))) : 8'(v[m] ^ p[m]);
    return r;
  endfunction : pins_exp
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d);
    dof_master_i.access(1'b1, i, s, d, rd, er, ak);
    chk(ak, 1'b1);
    if (i == IDX_VALUE || i == IDX_POL) flt = 1'b0;
    if (i == IDX_VALUE) v[s-1] = d[7:0];
    if (i == IDX_POL) p[s-1] = d[7:0];
    if (i == IDX_FMODE) fm[s-1] = d[7:0];
    if (i == IDX_FSUBST) fs[s-1] = d[7:0];
  endtask : wr
  task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [15:0] exp);
    dof_master_i.access(1'b0, i, s, 16'h0000, rd, er, ak);
    chk(rd, exp);
  endtask : rdc
  always @(posedge mclk) if (emcy_req === 1'b1) n_emcy++;
  initial forever #2 mclk = ~mclk;
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h3c8406c4));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int m = 1; m <= NUM_MOD; m++) rdc(IDX_MASK, 8'(m), {8'h00, MASK_RST});
    rdc(IDX_VALUE, SUB_COUNT, MOD_COUNT);
    for (int m = 1; m <= NUM_MOD; m++)
      for (int k = 0; k < 4; k++) wr(rw_idx[k], 8'(m), 16'($urandom & 8'hff));
    chk(out_pins, pins_exp());
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk);
      {life_guard_fail, bus_off} = 2'(k + 1);
      @(negedge mclk);
      {life_guard_fail, bus_off} = 2'b00;
      flt = 1'b1;
      repeat (3) @(negedge mclk);
      chk(fault_active, 1'b1);
      chk(out_pins, pins_exp());
      wr(IDX_POL, 8'(k + 1), 16'($urandom & 8'hff));
      chk(out_pins, pins_exp());
    end
    wr(IDX_FMODE, SUB_FIRST, 16'h0000);
    wr(IDX_VALUE, SUB_FIRST, 16'((8'h03 ^ p[0]) & 8'hff));
    diag_detect[1:0] = 2'b11;
    repeat (2) @(negedge mclk);
    flt = 1'b1;
    chk(fault_active, 1'b1);
    chk(out_pins, pins_exp());
    rdc(IDX_DIAG, SUB_FIRST, 16'h0021);
    rdc(IDX_SUMMARY, SUB_COUNT, 16'h0001);
    chk(n_emcy, 1);
    wr(IDX_DIAG, SUB_FIRST, 16'h0000);
    chk(er, 1'b1);
    diag_detect = 36'h1;
    wr(IDX_VALUE, SUB_FIRST, 16'((8'h07 ^ p[0]) & 8'hff));
    diag_detect = '0;
    rdc(IDX_DIAG, SUB_FIRST, 16'h0021);
    wr(IDX_ERR_RST, SUB_COUNT, ERR_RST_DO);
    rdc(IDX_DIAG, SUB_FIRST, 16'h0000);
    wr(IDX_MASK, SUB_FIRST, 16'h0000);
    diag_detect[0] = 1'b1;
    rdc(IDX_DIAG, SUB_FIRST, 16'h0001);
    chk(fault_active, 1'b0);
    chk(n_emcy, 1);
    diag_detect = '0;
    rdc(IDX_DIAG, SUB_FIRST, 16'h0000);
    rdc(16'h6000, SUB_FIRST, 16'h0000);
    chk(er, 1'b1);
    wrap_up();
  end
endmodule : digital_output_fault_control_bench
`default_nettype wire
